// file: balance_selftest_result_defs.vh
/*
 * register indices, byte addresses, field positions and reset values
 * for the balancing-switch diagnostic threshold bank.
 * assumes: included by bare name from every design file that needs it.
 */
`ifndef BALANCE_SELFTEST_RESULT_DEFS_VH
`define BALANCE_SELFTEST_RESULT_DEFS_VH

// register indices as printed; the byte address is four times the index
`define IDX_BAL_LOW_THR 8'h4C
`define IDX_BAL_HIGH_THR 8'h4D
`define IDX_SELFTEST_RESULT 8'h50
`define IDX_SELFTEST_CONFIG 8'h51
`define IDX_ALERT_STATUS 8'h52
`define IDX_ALERT_MASK 8'h53

// byte addresses on the apb side
`define ADDR_BAL_LOW_THR 12'h130
`define ADDR_BAL_HIGH_THR 12'h134
`define ADDR_SELFTEST_RESULT 12'h140
`define ADDR_SELFTEST_CONFIG 12'h144
`define ADDR_ALERT_STATUS 12'h148
`define ADDR_ALERT_MASK 12'h14C

// field layout of the 16-bit threshold and result words
`define VAL_MSB 15
`define VAL_LSB 2
`define VAL_WIDTH 14
`define REG_WIDTH 16

// selftest_config fields
`define CFG_SEL_MSB 2
`define CFG_SEL_LSB 0
`define CFG_WIDTH 3

// alert status / mask bit positions
`define ST_LOW_ALERT 0
`define ST_HIGH_ALERT 1
`define ST_RESULT_READY 2
`define ST_WIDTH 3

// reset values; thresholds and result are held as their 14-bit fields
`define RST_THRESHOLD 14'h0000
`define RST_RESULT 14'h0000
`define RST_CONFIG 3'h0
`define RST_MASK 3'h0

`endif

// file: threshold_compare.v
/*
 * window comparator for one diagnostic conversion against the two thresholds.
 * assumes: inputs are stable 14-bit unsigned values in the clk domain.
 */
`timescale 1ns/1ps
`include "balance_selftest_result_defs.vh"

module threshold_compare #(
	parameter W = `VAL_WIDTH
) (
	input wire enable,
	input wire [W-1:0] sample,
	input wire [W-1:0] lowLimit,
	input wire [W-1:0] highLimit,
	output wire belowLow,
	output wire aboveHigh
);

	// strict unsigned tests; equal to a limit counts as normal
	assign belowLow = enable && (sample < lowLimit);
	assign aboveHigh = enable && (sample > highLimit);

endmodule

// file: alert_status.v
/*
 * sticky event bits with mask gating onto one level interrupt.
 * assumes: set pulses and the read-clear strobe are in the clk domain.
 */
`timescale 1ns/1ps

module alert_status #(
	parameter N = 3
) (
	input wire clk,
	input wire resetn,
	input wire [N-1:0] eventSet,
	input wire readClear,
	input wire [N-1:0] mask,
	output wire [N-1:0] status,
	output wire irq
);

	reg [N-1:0] sticky_r;
	genvar i;

	// set beats the read-clear so an event in the clearing cycle survives
	generate
		for (i = 0; i < N; i = i + 1) begin : g_bit
			always @(posedge clk) begin
				if (!resetn) begin
					sticky_r[i] <= 1'b0;
				end else if (eventSet[i]) begin
					sticky_r[i] <= 1'b1;
				end else if (readClear) begin
					sticky_r[i] <= 1'b0;
				end
			end
		end
	endgenerate

	assign status = sticky_r;
	// a mask bit of one lets its status bit through
	assign irq = |(sticky_r & mask);

endmodule

// file: balance_selftest_result_regs.v
/*
 * balancing-switch diagnostic threshold bank with apb slave,
 * result capture, window compare and alert interrupt.
 * register map, one aligned 32-bit word each, value in bits 15:0:
 *   0x130 balance_low_threshold, read/write, limit in bits 15:2
 *   0x134 balance_high_threshold, read/write, limit in bits 15:2
 *   0x140 selftest_result, read-only, last conversion in bits 15:2
 *   0x144 selftest_config, read/write, test select in bits 2:0
 *   0x148 alert status, read-only, cleared by a read
 *   0x14C alert mask, read/write, a one passes the matching status bit
 * status and mask bits: 0 below low limit, 1 above high limit,
 * 2 a conversion arrived.
 * bits 1:0 of every value word and the whole upper half read zero.
 * unmapped, unaligned and read-only writes answer with pslverr.
 * the window compare runs only while one of the two compared tests
 * is selected; other tests still store their result.
 * assumes: conversion results arrive as a one-cycle valid with data,
 * synchronous to clk; the apb master follows the usual two-phase protocol
 * and never starts an access without the setup cycle before it;
 * zero wait states, so every access cycle ends at its first edge.
 */
`timescale 1ns/1ps
`include "balance_selftest_result_defs.vh"

// Overview of operation
// - low threshold is 14-bit lower limit
// - result below low threshold raises alert while a switch-conducting or sense-wire test is selected
// - high threshold is 14-bit upper limit
// - result above high threshold raises alert while a switch-conducting or sense-wire test is selected
// - low threshold bits 1:0 read zero
// - high threshold bits 1:0 read zero
// - result register holds selected 14-bit measurement
// - result register read-only, bits 1:0 zero
module balance_selftest_result_regs #(
	parameter ADDR_W = 12,
	parameter [2:0] SEL_BAL_COND = 3'h1,
	parameter [2:0] SEL_SENSE_WIRE = 3'h2
) (
	input wire clk,
	input wire resetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output wire pready,
	output reg [31:0] prdata,
	output reg pslverr,
	input wire measValid,
	input wire [`VAL_WIDTH-1:0] measData,
	output wire [`CFG_WIDTH-1:0] selftestSelect,
	output reg balanceAlert,
	output wire irq
);

	// register state
	reg [`VAL_WIDTH-1:0] lowThr_r;
	reg [`VAL_WIDTH-1:0] highThr_r;
	reg [`VAL_WIDTH-1:0] result_r;
	reg [`CFG_WIDTH-1:0] config_r;
	reg [`ST_WIDTH-1:0] mask_r;
	reg [`ST_WIDTH-1:0] statusSnap_r;
	reg setupSeen_r;

	// bus decode and next values
	reg [31:0] rdata_nxt;
	reg rerr_nxt;
	reg [`VAL_WIDTH-1:0] lowThr_nxt;
	reg [`VAL_WIDTH-1:0] highThr_nxt;
	reg [`CFG_WIDTH-1:0] config_nxt;
	reg [`ST_WIDTH-1:0] mask_nxt;

	wire setupPhase;
	wire accessPhase;
	wire wrAccess;
	wire rdAccess;
	wire [2:0] regSel;
	wire aligned;
	wire lowByteEn;
	wire highByteEn;
	wire statusRead;
	wire statusFresh;
	wire compareEnable;
	wire belowLow;
	wire aboveHigh;
	wire [`ST_WIDTH-1:0] statusBits;
	wire [`ST_WIDTH-1:0] eventSet;

	localparam [2:0] SEL_NONE = 3'h0;
	localparam [2:0] SEL_LOW = 3'h1;
	localparam [2:0] SEL_HIGH = 3'h2;
	localparam [2:0] SEL_RESULT = 3'h3;
	localparam [2:0] SEL_CONFIG = 3'h4;
	localparam [2:0] SEL_STATUS = 3'h5;
	localparam [2:0] SEL_MASK = 3'h6;

	// address to register select; shared by read mux, write path and clear
	function [2:0] decodeAddr;
		input [ADDR_W-1:0] a;
		begin
			case (a)
				`ADDR_BAL_LOW_THR: decodeAddr = SEL_LOW;
				`ADDR_BAL_HIGH_THR: decodeAddr = SEL_HIGH;
				`ADDR_SELFTEST_RESULT: decodeAddr = SEL_RESULT;
				`ADDR_SELFTEST_CONFIG: decodeAddr = SEL_CONFIG;
				`ADDR_ALERT_STATUS: decodeAddr = SEL_STATUS;
				`ADDR_ALERT_MASK: decodeAddr = SEL_MASK;
				default: decodeAddr = SEL_NONE;
			endcase
		end
	endfunction

	// place a 14-bit value in bits 15:2, bits 1:0 and the upper half zero
	function [31:0] packValue;
		input [`VAL_WIDTH-1:0] v;
		begin
			packValue = {16'h0000, v, 2'b00};
		end
	endfunction

	// merge a 16-bit write into a 14-bit value honouring byte strobes
	function [`VAL_WIDTH-1:0] mergeValue;
		input [`VAL_WIDTH-1:0] old;
		input [15:0] wd;
		input lo;
		input hi;
		reg [15:0] cur;
		begin
			cur = {old, 2'b00};
			if (lo) begin
				cur[7:0] = wd[7:0];
			end
			if (hi) begin
				cur[15:8] = wd[15:8];
			end
			mergeValue = cur[`VAL_MSB:`VAL_LSB];
		end
	endfunction

	// phases of the apb transfer
	assign setupPhase = psel && !penable;
	assign accessPhase = psel && penable;
	// an access only counts right after the setup that loaded its read data;
	// pready is constant, so an access is always exactly one cycle
	assign wrAccess = accessPhase && setupSeen_r && pwrite;
	assign rdAccess = accessPhase && setupSeen_r && !pwrite;
	assign regSel = decodeAddr(paddr);
	assign aligned = (paddr[1:0] == 2'b00);
	assign lowByteEn = pstrb[0];
	assign highByteEn = pstrb[1];

	// zero wait states: read data is registered in the setup cycle,
	// so the access cycle can always complete at once
	assign pready = 1'b1;

	// marks the cycle right after a setup edge; a stray enable alone
	// must not write, and its read data would be stale anyway
	always @(posedge clk) begin
		if (!resetn) begin
			setupSeen_r <= 1'b0;
		end else begin
			setupSeen_r <= setupPhase;
		end
	end

	// read mux and error decode, evaluated during setup
	always @* begin
		rdata_nxt = 32'h00000000;
		rerr_nxt = 1'b0;
		if (!aligned) begin
			rerr_nxt = 1'b1;
		end else begin
			case (regSel)
				SEL_LOW: begin
					rdata_nxt = packValue(lowThr_r);
				end
				SEL_HIGH: begin
					rdata_nxt = packValue(highThr_r);
				end
				SEL_RESULT: begin
					rdata_nxt = packValue(result_r);
					rerr_nxt = pwrite;
				end
				SEL_CONFIG: begin
					rdata_nxt = {29'h00000000, config_r};
				end
				SEL_STATUS: begin
					rdata_nxt = {29'h00000000, statusBits};
					rerr_nxt = pwrite;
				end
				SEL_MASK: begin
					rdata_nxt = {29'h00000000, mask_r};
				end
				default: begin
					rerr_nxt = 1'b1;
				end
			endcase
		end
	end

	// read data and error flag captured at the setup edge, held through access
	always @(posedge clk) begin
		if (!resetn) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (setupPhase) begin
			prdata <= rdata_nxt;
			pslverr <= rerr_nxt;
		end else if (!psel) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
	end

	// write path; writes to read-only or unmapped words are dropped
	always @* begin
		lowThr_nxt = lowThr_r;
		highThr_nxt = highThr_r;
		config_nxt = config_r;
		mask_nxt = mask_r;
		if (wrAccess && aligned) begin
			case (regSel)
				SEL_LOW: begin
					lowThr_nxt = mergeValue(lowThr_r, pwdata[15:0],
						lowByteEn, highByteEn);
				end
				SEL_HIGH: begin
					highThr_nxt = mergeValue(highThr_r, pwdata[15:0],
						lowByteEn, highByteEn);
				end
				SEL_CONFIG: begin
					if (lowByteEn) begin
						config_nxt = pwdata[`CFG_SEL_MSB:`CFG_SEL_LSB];
					end
				end
				SEL_MASK: begin
					if (lowByteEn) begin
						mask_nxt = pwdata[`ST_WIDTH-1:0];
					end
				end
				default: begin
					lowThr_nxt = lowThr_r;
				end
			endcase
		end
	end

	// software-written registers
	always @(posedge clk) begin
		if (!resetn) begin
			lowThr_r <= `RST_THRESHOLD;
			highThr_r <= `RST_THRESHOLD;
			config_r <= `RST_CONFIG;
			mask_r <= `RST_MASK;
		end else begin
			lowThr_r <= lowThr_nxt;
			highThr_r <= highThr_nxt;
			config_r <= config_nxt;
			mask_r <= mask_nxt;
		end
	end

	assign selftestSelect = config_r;

	// the result word only ever changes on a conversion; bus writes never
	// reach it, which keeps a stray write from masking a real fault
	always @(posedge clk) begin
		if (!resetn) begin
			result_r <= `RST_RESULT;
		end else if (measValid) begin
			result_r <= measData;
		end
	end

	// compare only while a switch-conducting or sense-wire test is selected
	assign compareEnable = measValid &&
		((config_r == SEL_BAL_COND) || (config_r == SEL_SENSE_WIRE));

	// limits are sampled live at each conversion, so thresholds must be
	// in place before the measurement is started
	threshold_compare #(
		.W(`VAL_WIDTH)
	) u_compare (
		.enable(compareEnable),
		.sample(measData),
		.lowLimit(lowThr_r),
		.highLimit(highThr_r),
		.belowLow(belowLow),
		.aboveHigh(aboveHigh)
	);

	// alert level follows the latest compared conversion
	always @(posedge clk) begin
		if (!resetn) begin
			balanceAlert <= 1'b0;
		end else if (compareEnable) begin
			balanceAlert <= belowLow || aboveHigh;
		end
	end

	// events into the sticky status
	assign eventSet[`ST_LOW_ALERT] = belowLow;
	assign eventSet[`ST_HIGH_ALERT] = aboveHigh;
	assign eventSet[`ST_RESULT_READY] = measValid;

	// status as the read will report it, frozen at the setup edge
	always @(posedge clk) begin
		if (!resetn) begin
			statusSnap_r <= {`ST_WIDTH{1'b0}};
		end else if (setupPhase) begin
			statusSnap_r <= statusBits;
		end
	end

	// an event landing between snapshot and clear was never reported,
	// so the clear is skipped then and the next read shows everything
	assign statusFresh = (statusSnap_r == statusBits);
	// read of the status word clears it at the completing access edge
	assign statusRead = rdAccess && aligned && (regSel == SEL_STATUS) && statusFresh;

	alert_status #(
		.N(`ST_WIDTH)
	) u_status (
		.clk(clk),
		.resetn(resetn),
		.eventSet(eventSet),
		.readClear(statusRead),
		.mask(mask_r),
		.status(statusBits),
		.irq(irq)
	);

endmodule

// file: balance_selftest_result_asserts.sv
/* port checker for the diagnostic threshold bank
   assumes: bound to balance_selftest_result_regs, one clock, sync reset */
`timescale 1ns/1ps
module balance_selftest_result_asserts (
	input wire clk,
	input wire resetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	input wire pready,
	input wire [31:0] prdata,
	input wire pslverr,
	input wire measValid,
	input wire [13:0] measData,
	input wire [2:0] selftestSelect,
	input wire balanceAlert,
	input wire irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// read setup, and a quiet status read access
	sequence rdSetup;
		psel && !penable && !pwrite;
	endsequence
	sequence stRead;
		psel && penable && !pwrite && paddr == 12'h148 && !measValid && !$past(measValid);
	endsequence
	ready_high_a: assert property (pready) else $error("pready low");
	reset_clear_a: assert property ($rose(resetn) |-> !balanceAlert && !irq && prdata == 32'h0)
		else $error("state not cleared by reset");
	low_bits_a: assert property (rdSetup ##0 (paddr == 12'h130 || paddr == 12'h134
		|| paddr == 12'h140) |=> prdata[1:0] == 2'h0) else $error("low bits not zero");
	upper_zero_a: assert property (rdSetup |=> prdata[31:16] == 16'h0) else $error("upper half set");
	idle_zero_a: assert property (!psel |=> prdata == 32'h0 && !pslverr) else $error("idle read data");
	ro_write_a: assert property (psel && !penable && pwrite && paddr == 12'h140 |=> pslverr)
		else $error("result write accepted");
	cfg_hold_a: assert property (!(psel && penable && pwrite && paddr == 12'h144)
		|=> $stable(selftestSelect)) else $error("select moved");
	alert_hold_a: assert property (!measValid [*2] |=> $stable(balanceAlert))
		else $error("alert moved without conversion");
	irq_clear_a: assert property (stRead |=> !irq) else $error("irq stays after status read");
endmodule

// file: apb_master.sv
/* apb master standing in for the system controller
   assumes: bench owns the clock; slave answers through pready */
`timescale 1ns/1ps
module apb_master (
	input wire clk,
	input wire pready,
	input wire [31:0] prdata,
	input wire pslverr,
	output logic psel = 1'b0,
	output logic penable = 1'b0,
	output logic pwrite = 1'b0,
	output logic [11:0] paddr = 12'h000,
	output logic [31:0] pwdata = 32'h0,
	output logic [3:0] pstrb = 4'hF
);
	logic [31:0] rdata = 32'h0;
	logic slvErr = 1'b0;
	logic timedOut = 1'b0;
	// request held until pready is seen at a rising edge
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		timedOut = (pready !== 1'b1);
		rdata = prdata;
		slvErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
endmodule

// file: tb_top.sv
/* self-checking bench for the diagnostic threshold bank
   assumes: apb_master drives the bus, bench drives conversions */
`timescale 1ns/1ps
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin failCount++; \
	$display("mismatch at %0t got %h exp %h", $time, g, e); end end
module tb_top;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic measValid = 1'b0;
	logic [13:0] measData = 14'h0;
	wire psel, penable, pwrite, pready, pslverr, balanceAlert, irq;
	wire [11:0] paddr;
	wire [31:0] pwdata, prdata;
	wire [3:0] pstrb;
	wire [2:0] selftestSelect;
	logic [31:0] rd;
	logic err;
	int failCount = 0;
	int totalChecks = 0;
	typedef struct {logic [15:0] lo, hi; logic [2:0] sel; logic [13:0] m; logic al;} row_t;
	// equal-to-limit rows catch a non-strict compare; sel 3 and 0 must not touch the alert
	row_t rows[6] = '{'{16'h1003, 16'h2003, 3'h1, 14'h03FF, 1'b1},
		'{16'h1003, 16'h2003, 3'h1, 14'h0400, 1'b0}, '{16'h1003, 16'h2003, 3'h2, 14'h0800, 1'b0},
		'{16'h1003, 16'h2003, 3'h2, 14'h0801, 1'b1}, '{16'h1003, 16'h2003, 3'h3, 14'h0000, 1'b1},
		'{16'h1003, 16'h2003, 3'h0, 14'h0000, 1'b1}};
	apb_master m_u (.clk(clk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
	balance_selftest_result_regs dut_u (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .measValid(measValid), .measData(measData),
		.selftestSelect(selftestSelect), .balanceAlert(balanceAlert), .irq(irq));
	initial begin
		forever #5 clk = ~clk;
	end
	task completeRun;
		$display("checks %0d mismatches %0d", totalChecks, failCount);
		if (failCount == 0 && totalChecks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		m_u.xfer(w, a, d);
		rd = m_u.rdata;
		err = m_u.slvErr;
		if (m_u.timedOut) begin
			failCount++;
			completeRun;
		end
	endtask
	// one-cycle conversion pulse, then time for alert and status to land
	task meas(input logic [13:0] v);
		@(posedge clk);
		measValid <= 1'b1;
		measData <= v;
		@(posedge clk);
		measValid <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		foreach (rows[i]) begin
			bus(1'b1, 12'h130, {16'h0, rows[i].lo});
			bus(1'b1, 12'h134, {16'h0, rows[i].hi});
			bus(1'b1, 12'h144, {29'h0, rows[i].sel});
			`CHK(selftestSelect, rows[i].sel)
			bus(1'b0, 12'h130, 32'h0);
			`CHK(rd, {16'h0, rows[i].lo[15:2], 2'h0})
			bus(1'b0, 12'h134, 32'h0);
			`CHK(rd, {16'h0, rows[i].hi[15:2], 2'h0})
			meas(rows[i].m);
			`CHK(balanceAlert, rows[i].al)
			bus(1'b0, 12'h140, 32'h0);
			`CHK(rd, {16'h0, rows[i].m, 2'h0})
		end
		// refused writes and unmapped place
		bus(1'b1, 12'h140, 32'hFFFF);
		`CHK(err, 1'b1)
		bus(1'b0, 12'h140, 32'h0);
		`CHK(rd, 32'h0)
		bus(1'b0, 12'h1F0, 32'h0);
		`CHK(err, 1'b1)
		bus(1'b0, 12'h131, 32'h0);
		`CHK(err, 1'b1)
		// masked, unmasked, then read-clear
		`CHK(irq, 1'b0)
		bus(1'b1, 12'h14C, 32'h7);
		`CHK(irq, 1'b1)
		bus(1'b0, 12'h148, 32'h0);
		`CHK(rd, 32'h7)
		`CHK(irq, 1'b0)
		// a stored result and a standing alert give the reset something to clear
		meas(14'h2AB);
		`CHK(balanceAlert, 1'b1)
		@(posedge clk);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		#1;
		`CHK(balanceAlert, 1'b0)
		bus(1'b0, 12'h130, 32'h0);
		`CHK(rd, 32'h0)
		bus(1'b0, 12'h134, 32'h0);
		`CHK(rd, 32'h0)
		bus(1'b0, 12'h140, 32'h0);
		`CHK(rd, 32'h0)
		completeRun;
	end
endmodule
bind balance_selftest_result_regs balance_selftest_result_asserts chk_u (.clk(clk), .resetn(resetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.pready(pready), .prdata(prdata), .pslverr(pslverr), .measValid(measValid),
	.measData(measData), .selftestSelect(selftestSelect), .balanceAlert(balanceAlert), .irq(irq));
